// ---- tb/pwm_pin_load.sv ----
module pwm_pin_load (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        pin,
    input  wire logic        pin_oe,
    output logic             level,
    output logic [15:0]      period,
    output logic [15:0]      high_time,
    output logic [15:0]      edges
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [15:0] cnt_q;
    logic        last_q;

    // ------------------------------------------------------------
    // Pin wire with pull-down load
    // ------------------------------------------------------------
    // An undriven pin sinks to the pull-down, never keeps its last level
    assign level = pin_oe ? pin : 1'b0;

    // ------------------------------------------------------------
    // Period and high-time meter
    // ------------------------------------------------------------
    // Period from rising edge to rising edge, high time from rising to falling edge, in sys_clk cycles
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q     <= 16'h0000;
            last_q    <= 1'b0;
            period    <= 16'h0000;
            high_time <= 16'h0000;
            edges     <= 16'h0000;
        end else begin
            cnt_q  <= cnt_q + 16'h0001;
            last_q <= level;
            if (level != last_q) begin
                edges <= edges + 16'h0001;
            end
            if (level && !last_q) begin
                period <= cnt_q;
                cnt_q  <= 16'h0001;
            end
            if (!level && last_q) begin
                high_time <= cnt_q;
            end
        end
    end
endmodule : pwm_pin_load

// ---- tb/test_timer2_compare_pwm_unit.sv ----
module test_timer2_compare_pwm_unit;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct {
        logic [2:0] m;
        logic [1:0] c;
        logic [2:0] p;
        logic [7:0] v;
        int         per;
        int         hi;
    } pwm_case_t;

    logic        sys_clk;
    logic        rst_n;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        pin;
    logic        pin_oe;
    logic        irq;
    logic        level;
    logic [15:0] period;
    logic [15:0] high_time;
    logic [15:0] edges;
    logic [31:0] rd;
    int          failures;
    int          total_checks;
    // Last offset is unmapped
    logic [7:0]  offs [8] = '{8'h00, 8'h04, 8'h08, 8'h0c,
                              8'h10, 8'h14, 8'h18, 8'h1c};
    // Mode, output mode, prescale, compare, period, high time;
    // period 0 means a constant level equal to the last field
    pwm_case_t   tbl [10] = '{
        '{3'h3, 2'h2, 3'h1, 8'h40, 510, 128},
        '{3'h3, 2'h3, 3'h1, 8'h40, 510, 382},
        '{3'h3, 2'h2, 3'h2, 8'h40, 4080, 1024},
        '{3'h3, 2'h3, 3'h1, 8'hc0, 510, 126},
        '{3'h7, 2'h2, 3'h1, 8'h80, 256, -1},
        '{3'h3, 2'h2, 3'h1, 8'h00, 0, 0},
        '{3'h3, 2'h2, 3'h1, 8'hff, 0, 1},
        '{3'h3, 2'h3, 3'h1, 8'h00, 0, 1},
        '{3'h3, 2'h3, 3'h1, 8'hff, 0, 0},
        '{3'h2, 2'h1, 3'h1, 8'h20, 66, 33}
    };
    // Prescale factors for select codes 3 to 7
    int          fac [5] = '{32, 64, 128, 256, 1024};

    timer_pwm_unit u_dut (
        .sys_clk                (sys_clk),
        .rst_n                  (rst_n),
        .hsel                   (hsel),
        .haddr                  (haddr),
        .htrans                 (htrans),
        .hwrite                 (hwrite),
        .hsize                  (hsize),
        .hwdata                 (hwdata),
        .hready                 (hreadyout),
        .hrdata                 (hrdata),
        .hreadyout              (hreadyout),
        .hresp                  (hresp),
        .waveform_output_pin    (pin),
        .waveform_output_pin_oe (pin_oe),
        .irq                    (irq)
    );

    pwm_pin_load u_load (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .pin       (pin),
        .pin_oe    (pin_oe),
        .level     (level),
        .period    (period),
        .high_time (high_time),
        .edges     (edges)
    );

    initial sys_clk = 1'b0;
    always #2.5 sys_clk = ~sys_clk;

    // ------------------------------------------------------------
    // Bus and check tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // No wait count is assumed; only the watchdog ends a stuck wait
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= {24'h000000, a};
        htrans <= 2'b10;
        hwrite <= w;
        @(posedge sys_clk);
        while (hreadyout !== 1'b1) @(posedge sys_clk);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge sys_clk);
        while (hreadyout !== 1'b1) @(posedge sys_clk);
        rd = hrdata;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(rd, exp);
    endtask : rchk

    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : settle

    function automatic logic [31:0] ctrl(input logic [2:0] m,
        input logic [1:0] c, input logic dir, input logic [2:0] p);
        return {21'h0, p, 1'b0, dir, c, 1'b0, m};
    endfunction : ctrl

    task automatic run_case(input pwm_case_t t);
        int          n;
        logic [15:0] e0;
        n = (t.per == 0) ? 1100 : 2 * t.per + 40;
        wr(timer_pwm_pkg::OFF_CTRL, ctrl(t.m, t.c, 1'b1, 3'h0));
        // Direction is unknown here, so keep off BOTTOM
        wr(timer_pwm_pkg::OFF_COUNT, 32'h01);
        wr(timer_pwm_pkg::OFF_CMP, {24'h0, t.v});
        wr(timer_pwm_pkg::OFF_CTRL, ctrl(t.m, t.c, 1'b1, t.p));
        settle(n);
        e0 = edges;
        settle(n);
        if (t.per == 0) begin
            check({15'h0, level, edges}, {15'h0, t.hi[0], e0});
        end else begin
            check({16'h0, period}, t.per);
            if (t.hi >= 0) check({16'h0, high_time}, t.hi);
        end
    endtask : run_case

    task automatic stop_test();
        if (failures == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : stop_test

    // ------------------------------------------------------------
    // Watchdog
    // ------------------------------------------------------------
    initial begin
        #400000;
        failures++;
        stop_test();
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        failures = 0;
        total_checks = 0;
        rst_n = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        check({28'h0, hresp, pin, pin_oe, irq}, 32'h0);
        foreach (offs[i]) rchk(offs[i], 32'h0);
        wr(timer_pwm_pkg::OFF_CMP, 32'h20);
        rchk(timer_pwm_pkg::OFF_ACTIVE, 32'h20);
        wr(timer_pwm_pkg::OFF_COUNT, 32'h10);
        for (int i = 1; i < 4; i++) begin
            wr(timer_pwm_pkg::OFF_CTRL, ctrl(3'h0, i[1:0], 1'b1, 3'h0));
            wr(timer_pwm_pkg::OFF_FORCE, 32'h1);
            settle(2);
            check({31'h0, pin}, {31'h0, i != 2});
        end
        wr(timer_pwm_pkg::OFF_CTRL, ctrl(3'h2, 2'h1, 1'b1, 3'h0));
        wr(timer_pwm_pkg::OFF_FORCE, 32'h1);
        settle(2);
        check({31'h0, pin}, 32'h0);
        rchk(timer_pwm_pkg::OFF_STATUS, 32'h0);
        rchk(timer_pwm_pkg::OFF_COUNT, 32'h10);
        wr(timer_pwm_pkg::OFF_CTRL, ctrl(3'h0, 2'h3, 1'b0, 3'h0));
        wr(timer_pwm_pkg::OFF_FORCE, 32'h1);
        settle(2);
        check({30'h0, pin_oe, level}, 32'h0);
        wr(timer_pwm_pkg::OFF_CTRL, ctrl(3'h0, 2'h3, 1'b1, 3'h0));
        settle(2);
        check({30'h0, pin_oe, level}, 32'h3);
        // Counter loaded equal to compare while stopped, then started
        wr(timer_pwm_pkg::OFF_MASK, 32'h1);
        wr(timer_pwm_pkg::OFF_COUNT, 32'h20);
        wr(timer_pwm_pkg::OFF_CTRL, ctrl(3'h0, 2'h1, 1'b1, 3'h1));
        settle(4);
        check({30'h0, irq, pin}, 32'h1);
        rchk(timer_pwm_pkg::OFF_STATUS, 32'h0);
        settle(260);
        check({30'h0, irq, pin}, 32'h2);
        bus(1'b0, timer_pwm_pkg::OFF_STATUS, 32'h0);
        check(rd, 32'h3);
        settle(2);
        check({31'h0, irq}, 32'h0);
        wr(timer_pwm_pkg::OFF_MASK, 32'h0);
        // Buffered compare while the timer is stopped
        wr(timer_pwm_pkg::OFF_CTRL, ctrl(3'h3, 2'h2, 1'b1, 3'h0));
        wr(timer_pwm_pkg::OFF_CMP, 32'h40);
        rchk(timer_pwm_pkg::OFF_ACTIVE, 32'h20);
        rchk(timer_pwm_pkg::OFF_CMP, 32'h40);
        wr(timer_pwm_pkg::OFF_CTRL, ctrl(3'h3, 2'h2, 1'b1, 3'h1));
        settle(600);
        rchk(timer_pwm_pkg::OFF_ACTIVE, 32'h40);
        foreach (tbl[i]) run_case(tbl[i]);
        foreach (fac[i]) begin
            wr(timer_pwm_pkg::OFF_CTRL, ctrl(3'h0, 2'h0, 1'b1, 3'h0));
            wr(timer_pwm_pkg::OFF_COUNT, 32'h0);
            wr(timer_pwm_pkg::OFF_CTRL, ctrl(3'h0, 2'h0, 1'b1, 3'(i + 3)));
            settle(2 * fac[i] + 2);
            rchk(timer_pwm_pkg::OFF_COUNT, 32'h2);
        end
        stop_test();
    end
endmodule : test_timer2_compare_pwm_unit

// ---- verilog/timer_pwm_pkg.sv ----
// What this block does
// - PWM modes hold compare writes in a buffer, applied later.
// - Normal and clear-on-match modes apply compare writes at once.
// - Buffer copies to active compare only at TOP or BOTTOM.
// - Compare access hits buffer when buffering, else active register.
// - Force bit in non-PWM modes acts on output like a real match.
// - Forced compare sets no flag and leaves counter untouched.
// - Counter write blocks every match during the following timer tick.
// - Counter written equal to compare misses that match entirely.
// - Output mode three selects inverted phase correct PWM.
// - TOP is 0xFF in mode 3, channel compare value in mode 7.
// - Output reaches pin only when pin direction is output.
// - Clear on up-count match, set on down-count match, or inverted.
// - Period is 510 prescaled ticks in mode 3; prescale 1,8,32,64,128,256,1024.
// - Compare BOTTOM gives constant low, MAX constant high, inverted reversed.
// - At MAX the level changes at next period start without a match.
// - A missed up-count match still changes the output at BOTTOM.
// - Prescaled tick is a clock enable on the system clock.
package timer_pwm_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL    = 8'h00;
    localparam logic [7:0] OFF_FORCE   = 8'h04;
    localparam logic [7:0] OFF_COUNT   = 8'h08;
    localparam logic [7:0] OFF_CMP     = 8'h0c;
    localparam logic [7:0] OFF_ACTIVE  = 8'h10;
    localparam logic [7:0] OFF_STATUS  = 8'h14;
    localparam logic [7:0] OFF_MASK    = 8'h18;

    // ----------------------------------------------------------------
    // Control fields and reset values
    // ----------------------------------------------------------------
    localparam int         MODE_LSB    = 0;
    localparam int         COM_LSB     = 4;
    localparam int         DIR_BIT     = 6;
    localparam int         PRE_LSB     = 8;
    localparam logic [10:0] CTRL_RST   = 11'h000;
    localparam logic [7:0] CNT_RST     = 8'h00;
    localparam logic [7:0] CMP_RST     = 8'h00;
    localparam logic [1:0] ST_RST      = 2'h0;
    localparam int         ST_MATCH    = 0;
    localparam int         ST_BOTTOM   = 1;

    // ----------------------------------------------------------------
    // Modes and output actions
    // ----------------------------------------------------------------
    localparam logic [2:0] MODE_NORMAL = 3'h0;
    localparam logic [2:0] MODE_CLR    = 3'h2;
    localparam logic [2:0] MODE_PC_MAX = 3'h3;
    localparam logic [2:0] MODE_PC_CMP = 3'h7;
    localparam logic [1:0] COM_OFF     = 2'h0;
    localparam logic [1:0] COM_TOGGLE  = 2'h1;
    localparam logic [1:0] COM_CLEAR   = 2'h2;
    localparam logic [1:0] COM_SET     = 2'h3;
    localparam logic [7:0] VAL_BOTTOM  = 8'h00;
    localparam logic [7:0] VAL_MAX     = 8'hff;

    // ----------------------------------------------------------------
    // Prescale dividers, stored as count limits (factor minus one)
    // ----------------------------------------------------------------
    localparam logic [9:0] DIV_1       = 10'h000;
    localparam logic [9:0] DIV_8       = 10'h007;
    localparam logic [9:0] DIV_32      = 10'h01f;
    localparam logic [9:0] DIV_64      = 10'h03f;
    localparam logic [9:0] DIV_128     = 10'h07f;
    localparam logic [9:0] DIV_256     = 10'h0ff;
    localparam logic [9:0] DIV_1024    = 10'h3ff;

endpackage : timer_pwm_pkg

// ---- verilog/timer_pwm_unit.sv ----
module timer_pwm_unit (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             waveform_output_pin,
    output logic             waveform_output_pin_oe,
    output logic             irq
);

    // ----------------------------------------------------------------
    // Bus slave
    // ----------------------------------------------------------------
    logic        wr_q;
    logic [7:0]  addr_q;
    logic [31:0] hrdata_q;
    logic        hreadyout_q;
    logic        hresp_q;
    logic [10:0] ctrl_q;
    logic [7:0]  cnt_q;
    logic [7:0]  buf_q;
    logic [7:0]  active_q;
    logic [1:0]  status_q;
    logic [1:0]  mask_q;
    logic        oc_q;
    logic        up_q;
    logic        block_q;
    logic [9:0]  pre_q;
    logic        pin_q;
    logic        pin_oe_q;
    logic        irq_q;

    wire         accept    = hsel & htrans[1] & hready;
    wire         rd_accept = accept & ~hwrite;
    wire [7:0]   raddr     = haddr[7:0];
    wire         wr_ctrl   = wr_q & (addr_q == timer_pwm_pkg::OFF_CTRL);
    wire         wr_force  = wr_q & (addr_q == timer_pwm_pkg::OFF_FORCE);
    wire         wr_count  = wr_q & (addr_q == timer_pwm_pkg::OFF_COUNT);
    wire         wr_cmp    = wr_q & (addr_q == timer_pwm_pkg::OFF_CMP);
    wire         wr_mask   = wr_q & (addr_q == timer_pwm_pkg::OFF_MASK);
    wire         rd_status = rd_accept &
                             (raddr == timer_pwm_pkg::OFF_STATUS);

    // ----------------------------------------------------------------
    // Control fields
    // ----------------------------------------------------------------
    wire [2:0]   mode    = ctrl_q[timer_pwm_pkg::MODE_LSB +: 3];
    wire [1:0]   com     = ctrl_q[timer_pwm_pkg::COM_LSB +: 2];
    wire         dir_out = ctrl_q[timer_pwm_pkg::DIR_BIT];
    wire [2:0]   pre_sel = ctrl_q[timer_pwm_pkg::PRE_LSB +: 3];
    wire         pc_mode = (mode == timer_pwm_pkg::MODE_PC_MAX) |
                           (mode == timer_pwm_pkg::MODE_PC_CMP);
    wire         clr     = (mode == timer_pwm_pkg::MODE_CLR);
    wire         inv     = (com == timer_pwm_pkg::COM_SET);

    // Buffered view for software: buffer in PWM modes, even when stopped, else live value
    wire [7:0]   cmp_view = pc_mode ? buf_q : active_q;

    wire [31:0]  rd_mux =
        (raddr == timer_pwm_pkg::OFF_CTRL)   ? {21'h0, ctrl_q} :
        (raddr == timer_pwm_pkg::OFF_COUNT)  ? {24'h0, cnt_q} :
        (raddr == timer_pwm_pkg::OFF_CMP)    ? {24'h0, cmp_view} :
        (raddr == timer_pwm_pkg::OFF_ACTIVE) ? {24'h0, active_q} :
        (raddr == timer_pwm_pkg::OFF_STATUS) ? {30'h0, status_q} :
        (raddr == timer_pwm_pkg::OFF_MASK)   ? {30'h0, mask_q} :
        32'h0000_0000;

    // ----------------------------------------------------------------
    // Prescaler: the tick is an enable on sys_clk, never a clock
    // ----------------------------------------------------------------
    wire [9:0]   div_m1 =
        (pre_sel == 3'h1) ? timer_pwm_pkg::DIV_1 :
        (pre_sel == 3'h2) ? timer_pwm_pkg::DIV_8 :
        (pre_sel == 3'h3) ? timer_pwm_pkg::DIV_32 :
        (pre_sel == 3'h4) ? timer_pwm_pkg::DIV_64 :
        (pre_sel == 3'h5) ? timer_pwm_pkg::DIV_128 :
        (pre_sel == 3'h6) ? timer_pwm_pkg::DIV_256 :
        timer_pwm_pkg::DIV_1024;
    wire         run    = (pre_sel != 3'h0);
    wire         tick   = run & (pre_q == div_m1);
    wire [9:0]   pre_d  = (!run || tick) ? 10'h000 : pre_q + 10'h001;

    // ----------------------------------------------------------------
    // Counter
    // ----------------------------------------------------------------
    wire [7:0]   top     = (mode == timer_pwm_pkg::MODE_PC_CMP) ?
                           active_q : timer_pwm_pkg::VAL_MAX;
    wire         at_top  = (cnt_q == top);
    wire         at_bot  = (cnt_q == timer_pwm_pkg::VAL_BOTTOM);
    wire         eq      = (cnt_q == active_q);
    // A written counter masks the next tick's match, even when stopped
    wire         match   = tick & eq & ~block_q;
    wire [7:0]   cnt_inc = cnt_q + 8'h01;
    wire [7:0]   cnt_dec = cnt_q - 8'h01;
    // Up 0..TOP then down to 1: 2*255 ticks per period at TOP=0xFF
    wire [7:0]   cnt_pc  = up_q ? (at_top ? cnt_dec : cnt_inc) :
                                  (at_bot ? cnt_inc : cnt_dec);
    wire [7:0]   cnt_d   = wr_count ? hwdata[7:0] :
                           !tick    ? cnt_q :
                           pc_mode  ? cnt_pc :
                           (clr & match) ? timer_pwm_pkg::VAL_BOTTOM :
                           cnt_inc;
    wire         up_d    = !pc_mode ? 1'b1 :
                           !tick    ? up_q :
                           (up_q & at_top)  ? 1'b0 :
                           (~up_q & at_bot) ? 1'b1 : up_q;
    wire         block_d = wr_count ? 1'b1 : tick ? 1'b0 : block_q;

    // ----------------------------------------------------------------
    // Compare value and its double buffer
    // ----------------------------------------------------------------
    // Copy only at the turning points so no pulse is cut short
    wire         reload   = pc_mode & tick & (at_top | at_bot);
    wire [7:0]   buf_d    = wr_cmp ? hwdata[7:0] : buf_q;
    wire [7:0]   active_d = (wr_cmp & ~pc_mode) ? hwdata[7:0] :
                            reload ? buf_q : active_q;

    // ----------------------------------------------------------------
    // Waveform
    // ----------------------------------------------------------------
    wire         force_hit = wr_force & hwdata[0] & ~pc_mode;
    logic        np_oc;
    always_comb begin
        np_oc = oc_q;
        if (match | force_hit) begin
            case (com)
                timer_pwm_pkg::COM_TOGGLE: np_oc = ~oc_q;
                timer_pwm_pkg::COM_CLEAR:  np_oc = 1'b0;
                timer_pwm_pkg::COM_SET:    np_oc = 1'b1;
                default:                   np_oc = oc_q;
            endcase
        end
    end

    // Non-inverted level. BOTTOM starts the high half of a period
    // unless the compare sits at BOTTOM; this also restores symmetry
    // after a missed up match or a compare leaving MAX.
    logic        pc_lvl;
    logic        pc_hit;
    always_comb begin
        pc_lvl = oc_q ^ inv;
        pc_hit = 1'b0;
        if (tick & at_bot & ~up_q) begin
            pc_hit = 1'b1;
            pc_lvl = (buf_q != timer_pwm_pkg::VAL_BOTTOM);
        end else if (match & up_q) begin
            pc_hit = 1'b1;
            // At MAX the up match keeps the output high all period
            pc_lvl = (active_q == timer_pwm_pkg::VAL_MAX);
        end else if (match) begin
            pc_hit = 1'b1;
            pc_lvl = 1'b1;
        end
    end

    wire         pc_drive = (com == timer_pwm_pkg::COM_CLEAR) | inv;
    wire         oc_d     = !pc_mode ? np_oc :
                            (pc_drive & pc_hit) ? (pc_lvl ^ inv) :
                            oc_q;
    // Pin follows the compare output only when the output mode is not off
    wire         pin_d    = (com != timer_pwm_pkg::COM_OFF) & oc_d;
    wire         pin_oe_d = dir_out;

    // ----------------------------------------------------------------
    // Status and interrupt
    // ----------------------------------------------------------------
    wire [1:0]   st_set   = {tick & at_bot, match};
    // A fresh event in the clearing cycle survives the read
    wire [1:0]   status_d = (rd_status ? 2'b00 : status_q) | st_set;
    wire [1:0]   mask_d   = wr_mask ? hwdata[1:0] : mask_q;
    wire         irq_d    = |(status_d & mask_d);

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_q        <= 1'b0;
            addr_q      <= 8'h00;
            hrdata_q    <= 32'h0000_0000;
            hreadyout_q <= 1'b1;
            hresp_q     <= 1'b0;
        end else begin
            wr_q        <= accept & hwrite;
            addr_q      <= raddr;
            hrdata_q    <= rd_accept ? rd_mux : 32'h0000_0000;
            hreadyout_q <= 1'b1;
            hresp_q     <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q   <= timer_pwm_pkg::CTRL_RST;
            mask_q   <= timer_pwm_pkg::ST_RST;
            status_q <= timer_pwm_pkg::ST_RST;
            irq_q    <= 1'b0;
        end else begin
            ctrl_q   <= wr_ctrl ? hwdata[10:0] : ctrl_q;
            mask_q   <= mask_d;
            status_q <= status_d;
            irq_q    <= irq_d;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_q    <= 10'h000;
            cnt_q    <= timer_pwm_pkg::CNT_RST;
            up_q     <= 1'b1;
            block_q  <= 1'b0;
            buf_q    <= timer_pwm_pkg::CMP_RST;
            active_q <= timer_pwm_pkg::CMP_RST;
        end else begin
            pre_q    <= pre_d;
            cnt_q    <= cnt_d;
            up_q     <= up_d;
            block_q  <= block_d;
            buf_q    <= buf_d;
            active_q <= active_d;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            oc_q     <= 1'b0;
            pin_q    <= 1'b0;
            pin_oe_q <= 1'b0;
        end else begin
            oc_q     <= oc_d;
            pin_q    <= pin_d;
            pin_oe_q <= pin_oe_d;
        end
    end

    assign hrdata                 = hrdata_q;
    assign hreadyout              = hreadyout_q;
    assign hresp                  = hresp_q;
    assign waveform_output_pin    = pin_q;
    assign waveform_output_pin_oe = pin_oe_q;
    assign irq                    = irq_q;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    property p_direct_cmp;
        wr_cmp & ~pc_mode |=> active_q == $past(hwdata[7:0]);
    endproperty
    a_direct_cmp: assert property (p_direct_cmp)
        else $error("compare write not applied at once");

    property p_buffered_cmp;
        pc_mode & $past(pc_mode) & (active_q != $past(active_q)) |->
            $past(reload);
    endproperty
    a_buffered_cmp: assert property (p_buffered_cmp)
        else $error("active compare changed off TOP or BOTTOM");

    property p_force_no_flag;
        force_hit & ~match & ~status_q[timer_pwm_pkg::ST_MATCH] &
            ~rd_status |=> ~status_q[timer_pwm_pkg::ST_MATCH];
    endproperty
    a_force_no_flag: assert property (p_force_no_flag)
        else $error("forced compare set the flag");

    property p_force_toggle;
        force_hit & ~match & (com == timer_pwm_pkg::COM_TOGGLE) |=>
            oc_q != $past(oc_q);
    endproperty
    a_force_toggle: assert property (p_force_toggle)
        else $error("forced toggle did not toggle");

    sequence s_count_written;
        wr_count ##1 (~tick & ~wr_count)[*2];
    endsequence
    property p_block_held;
        s_count_written |-> block_q & ~match;
    endproperty
    a_block_held: assert property (p_block_held)
        else $error("match not blocked after counter write");

    property p_equal_missed;
        tick & eq & block_q & ~status_q[timer_pwm_pkg::ST_MATCH] &
            ~rd_status |=> ~status_q[timer_pwm_pkg::ST_MATCH];
    endproperty
    a_equal_missed: assert property (p_equal_missed)
        else $error("blocked match raised the flag");

    property p_match_flag;
        match |=> status_q[timer_pwm_pkg::ST_MATCH];
    endproperty
    a_match_flag: assert property (p_match_flag)
        else $error("real match did not set the flag");

    property p_turn_at_top;
        pc_mode & tick & up_q & at_top & ~wr_count |=> ~up_q;
    endproperty
    a_turn_at_top: assert property (p_turn_at_top)
        else $error("counter did not turn at TOP");

    property p_pin_dir;
        ~dir_out |=> ~waveform_output_pin_oe;
    endproperty
    a_pin_dir: assert property (p_pin_dir)
        else $error("pin driven while set as input");

    property p_up_match_level;
        pc_mode & match & up_q & ~at_bot & pc_drive &
            (active_q != timer_pwm_pkg::VAL_MAX) |=> oc_q == $past(inv);
    endproperty
    a_up_match_level: assert property (p_up_match_level)
        else $error("wrong level after up-count match");

    property p_down_match_level;
        pc_mode & match & ~up_q & ~at_bot & pc_drive |=>
            oc_q == ~$past(inv);
    endproperty
    a_down_match_level: assert property (p_down_match_level)
        else $error("wrong level after down-count match");

    property p_max_high;
        pc_mode & match & up_q & pc_drive &
            (active_q == timer_pwm_pkg::VAL_MAX) |=> oc_q == ~$past(inv);
    endproperty
    a_max_high: assert property (p_max_high)
        else $error("compare at MAX did not hold the high level");

    property p_reload_copy;
        reload |=> active_q == $past(buf_q);
    endproperty
    a_reload_copy: assert property (p_reload_copy)
        else $error("buffer not copied at TOP or BOTTOM");

    property p_turn_at_bottom;
        pc_mode & tick & ~up_q & at_bot |=> up_q;
    endproperty
    a_turn_at_bottom: assert property (p_turn_at_bottom)
        else $error("counter did not turn at BOTTOM");

    property p_top_is_cmp;
        (mode == timer_pwm_pkg::MODE_PC_CMP) & tick & up_q & eq &
            ~wr_count |=> ~up_q;
    endproperty
    a_top_is_cmp: assert property (p_top_is_cmp)
        else $error("compare value did not act as TOP");

    property p_count_on_tick;
        ~tick & ~wr_count |=> cnt_q == $past(cnt_q);
    endproperty
    a_count_on_tick: assert property (p_count_on_tick)
        else $error("counter moved without a timer tick");

    property p_pin_on;
        dir_out |=> waveform_output_pin_oe;
    endproperty
    a_pin_on: assert property (p_pin_on)
        else $error("pin not driven while set as output");

endmodule : timer_pwm_unit
